/* File: design/liu_local_unit.v */
// liu_local_unit.v: per-processor local interrupt unit, top module
// assumes core, peer units and redirection unit on the same clock; pins are async
//
// Overview of operation
// RULE1 - clearing software enable keeps registers but sets every vector-table mask
// RULE2 - while disabled only init, sysmgmt, nmi and start-up messages are accepted
// RULE3 - nmi and init are edge triggered except init deassert
// RULE4 - command-register messages go out edge triggered except init deassert
// RULE5 - logical destination register holds eight bits for logical matching
// RULE6 - unit id is four bits early, eight bits late
// RULE7 - late variant rejects remote-read delivery
// RULE8 - lowest-priority arbitration joined only with a free interrupt slot
// RULE9 - cluster addressing supported; flat model rejected in late variant
// RULE10 - software bit enables or disables focus checking
// RULE11 - late variant never claims lowest-priority by focus
// RULE12 - each local pin has programmable polarity
// RULE13 - system-management messages sent and received by command register and redirection
// RULE14 - errors logged in status register and reported through error entry
// RULE15 - vector-table entry for performance counter overflow
// RULE16 - late variant has a thermal entry
// RULE17 - after nmi, further nmi masked until first interrupt return
// RULE18 - build parameter selects early or late variant
`include "liu_consts.vh"
module liu_local_unit #(
  parameter LATE = `LIU_VAR_LATE // RULE18
) (
  input  wire        ref_clk_i,
  input  wire        rst_i,
  // configuration
  input  wire        sw_enable_i,
  input  wire [7:0]  unit_id_i,
  input  wire [7:0]  logical_dest_i,
  input  wire [3:0]  dest_format_i,
  input  wire        focus_check_en_i,
  input  wire [7:0]  task_priority_i,
  input  wire        lvt_wr_i,
  input  wire [2:0]  lvt_sel_i,
  input  wire [16:0] lvt_wdata_i,
  input  wire [2:0]  lvt_rsel_i,
  output reg  [16:0] lvt_rdata_o,
  input  wire        err_clr_i,
  output reg  [7:0]  err_status_o,
  output reg  [7:0]  unit_id_o,
  output reg  [7:0]  logical_dest_o,
  // local sources
  input  wire        lint0_pin_i,
  input  wire        local_interrupt_pin_one_pin_i,
  input  wire        timer_evt_i,
  input  wire        perf_ovf_i,
  input  wire        thermal_evt_i,
  // incoming messages from peers and redirection unit
  input  wire        msg_valid_i,
  input  wire [2:0]  msg_mode_i,
  input  wire [7:0]  msg_vector_i,
  input  wire        msg_logical_i,
  input  wire [7:0]  msg_dest_i,
  input  wire        msg_level_i,
  input  wire        msg_assert_i,
  input  wire        msg_focus_i,
  output wire        msg_accept_o,
  output wire        arb_join_o,
  output wire        focus_claim_o,
  // outgoing command-register messages
  input  wire        cmd_wr_i,
  input  wire [2:0]  cmd_mode_i,
  input  wire [7:0]  cmd_vector_i,
  input  wire        cmd_logical_i,
  input  wire [7:0]  cmd_dest_i,
  input  wire        cmd_level_i,
  input  wire        cmd_assert_i,
  output reg         out_valid_o,
  output reg  [2:0]  out_mode_i_unused_o,
  output reg  [7:0]  out_vector_o,
  output reg         out_logical_o,
  output reg  [7:0]  out_dest_o,
  output reg         out_level_o,
  output reg         out_assert_o,
  // core side
  output reg         core_intr_o,
  output reg  [7:0]  core_vector_o,
  input  wire        core_ack_i,
  output reg         core_nmi_o,
  output reg         core_smi_o,
  output reg         core_init_o,
  output reg         core_startup_o,
  input  wire        core_interrupt_return_instruction_i
);

  // helpers
  function dest_match;
    input       logical;
    input [7:0] dest;
    input [7:0] id;
    input [7:0] ldr;
    input [3:0] dfr;
    begin
      if (!logical) begin
        dest_match = (dest == id) || (dest == `LIU_DEST_ALL);
      end else if (dfr == `LIU_DFR_FLAT) begin
        dest_match = |(dest & ldr);
      end else begin
        dest_match = (dest[7:4] == ldr[7:4] || dest[7:4] == `LIU_CLUS_ALL) && |(dest[3:0] & ldr[3:0]);
      end
    end
  endfunction

  function mode_legal;
    input [2:0] mode;
    input       late;
    begin
      mode_legal = !(late && mode == `LIU_DM_REMOTE);
    end
  endfunction

  // RULE3/RULE4: init deassert is the only level-kept message
  function edge_forced;
    input [2:0] mode;
    input       lvl;
    input       asrt;
    begin
      if (mode == `LIU_DM_INIT && lvl && !asrt) begin
        edge_forced = 1'b0;
      end else begin
        edge_forced = 1'b1;
      end
    end
  endfunction

  // variant-trimmed identity
  wire [7:0] id_eff = LATE ? unit_id_i : {4'h0, unit_id_i[`LIU_ID_W_EARLY-1:0]}; // RULE6
  wire       flat_ok = !(LATE && dest_format_i == `LIU_DFR_FLAT); // RULE9

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      unit_id_o      <= 8'h00;
      logical_dest_o <= 8'h00;
    end else begin
      unit_id_o      <= id_eff; // RULE6
      logical_dest_o <= logical_dest_i; // RULE5
    end
  end

  // local vector table
  reg [16:0] lvt_q [0:5];
  reg        en_q;
  integer    k;
  wire       lvt_present = LATE || (lvt_sel_i != `LIU_LVT_THERM); // RULE16
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_q <= 1'b0;
      for (k = 0; k < `LIU_LVT_N; k = k + 1) begin
        lvt_q[k] <= `LIU_LVT_RST;
      end
    end else begin
      en_q <= sw_enable_i;
      if (lvt_wr_i && lvt_present && lvt_sel_i < `LIU_LVT_N) begin
        lvt_q[lvt_sel_i] <= lvt_wdata_i;
      end
      if (!sw_enable_i) begin
        for (k = 0; k < `LIU_LVT_N; k = k + 1) begin
          lvt_q[k][`LIU_LVT_MASK] <= 1'b1; // RULE1
        end
      end
    end
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lvt_rdata_o <= 17'h00000;
    end else if (lvt_rsel_i < `LIU_LVT_N && (LATE || lvt_rsel_i != `LIU_LVT_THERM)) begin
      lvt_rdata_o <= lvt_q[lvt_rsel_i];
    end else begin
      lvt_rdata_o <= 17'h00000;
    end
  end

  // pins
  wire lint0_s;
  wire local_interrupt_pin_one_s;
  liu_pin_sync u_sync0 (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .pin_i     (lint0_pin_i),
    .level_o   (lint0_s)
  );
  liu_pin_sync u_sync1 (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .pin_i     (local_interrupt_pin_one_pin_i),
    .level_o   (local_interrupt_pin_one_s)
  );
  wire lint0_act = lint0_s ^ lvt_q[`LIU_LVT_LINT0][`LIU_LVT_POL]; // RULE12
  wire local_interrupt_pin_one_act = local_interrupt_pin_one_s ^ lvt_q[`LIU_LVT_LOCAL_INTERRUPT_PIN_ONE][`LIU_LVT_POL]; // RULE12

  // local source edge detect
  reg [5:0] src_prev_q;
  wire [5:0] src_now = {thermal_evt_i & LATE[0], perf_ovf_i, 1'b0, local_interrupt_pin_one_act, lint0_act, timer_evt_i};
  wire [5:0] src_rise = src_now & ~src_prev_q;

  // errors
  reg [7:0] err_q;
  reg       err_evt_q;
  wire      rx_bad_mode = msg_valid_i && !mode_legal(msg_mode_i, LATE[0]); // RULE7
  wire      rx_bad_vec = msg_valid_i && msg_mode_i == `LIU_DM_FIXED && msg_vector_i < `LIU_VEC_MIN;
  wire      tx_bad_mode = cmd_wr_i && !mode_legal(cmd_mode_i, LATE[0]); // RULE7
  wire [7:0] err_set = ({7'h00, rx_bad_mode | rx_bad_vec} << `LIU_ERR_RECV)
                     | ({7'h00, tx_bad_mode} << `LIU_ERR_SEND)
                     | ({7'h00, rx_bad_vec} << `LIU_ERR_ILLVEC)
                     | ({7'h00, rx_bad_mode | tx_bad_mode} << `LIU_ERR_ILLMODE);
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      err_q      <= `LIU_ERR_RST;
      err_evt_q  <= 1'b0;
      src_prev_q <= 6'h00;
    end else begin
      err_q      <= (err_clr_i ? `LIU_ERR_RST : err_q) | err_set; // RULE14
      err_evt_q  <= |err_set; // RULE14
      src_prev_q <= src_now;
    end
  end
  always @* begin
    err_status_o = err_q;
  end

  // incoming message acceptance
  wire hit = msg_valid_i && flat_ok && mode_legal(msg_mode_i, LATE[0]) &&
             dest_match(msg_logical_i, msg_dest_i, id_eff, logical_dest_i, dest_format_i); // RULE9
  wire allowed_disabled = (msg_mode_i == `LIU_DM_INIT) || (msg_mode_i == `LIU_DM_SMI) ||
                          (msg_mode_i == `LIU_DM_NMI) || (msg_mode_i == `LIU_DM_STARTUP);
  wire mode_ok = en_q || allowed_disabled; // RULE2
  reg  slot_busy_q;
  wire is_lowest = msg_mode_i == `LIU_DM_LOWEST;
  assign arb_join_o = hit && en_q && is_lowest && !slot_busy_q; // RULE8
  assign focus_claim_o = !LATE[0] && focus_check_en_i && msg_focus_i && arb_join_o; // RULE10 RULE11
  assign msg_accept_o = hit && mode_ok && (!is_lowest || arb_join_o) && !rx_bad_vec;

  // nmi mask
  reg  nmi_block_q;
  wire nmi_edge = msg_accept_o && msg_mode_i == `LIU_DM_NMI &&
                  edge_forced(msg_mode_i, msg_level_i, msg_assert_i); // RULE3
  wire init_go  = msg_accept_o && msg_mode_i == `LIU_DM_INIT &&
                  edge_forced(msg_mode_i, msg_level_i, msg_assert_i); // RULE3
  wire lint_nmi = (src_rise[`LIU_LVT_LINT0] && !lvt_q[`LIU_LVT_LINT0][`LIU_LVT_MASK] &&
                   lvt_q[`LIU_LVT_LINT0][`LIU_LVT_MODE_HI:`LIU_LVT_MODE_LO] == `LIU_DM_NMI) ||
                  (src_rise[`LIU_LVT_LOCAL_INTERRUPT_PIN_ONE] && !lvt_q[`LIU_LVT_LOCAL_INTERRUPT_PIN_ONE][`LIU_LVT_MASK] &&
                   lvt_q[`LIU_LVT_LOCAL_INTERRUPT_PIN_ONE][`LIU_LVT_MODE_HI:`LIU_LVT_MODE_LO] == `LIU_DM_NMI);
  wire nmi_req  = nmi_edge || lint_nmi;

  // pick pending local vector
  reg       lv_hit;
  reg [7:0] lv_vec;
  integer   j;
  always @* begin
    lv_hit = 1'b0;
    lv_vec = 8'h00;
    for (j = `LIU_LVT_N - 1; j >= 0; j = j - 1) begin
      if ((src_rise[j] || (j == `LIU_LVT_ERROR && err_evt_q)) && !lvt_q[j][`LIU_LVT_MASK] && // RULE14
          lvt_q[j][`LIU_LVT_MODE_HI:`LIU_LVT_MODE_LO] == `LIU_DM_FIXED) begin // RULE15 RULE16
        lv_hit = 1'b1;
        lv_vec = lvt_q[j][7:0];
      end
    end
  end

  wire fixed_msg = msg_accept_o && (msg_mode_i == `LIU_DM_FIXED || is_lowest);
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      nmi_block_q    <= 1'b0;
      core_nmi_o     <= 1'b0;
      core_smi_o     <= 1'b0;
      core_init_o    <= 1'b0;
      core_startup_o <= 1'b0;
      core_intr_o    <= 1'b0;
      core_vector_o  <= 8'h00;
      slot_busy_q    <= 1'b0;
    end else begin
      core_nmi_o     <= nmi_req && !nmi_block_q; // RULE17
      core_smi_o     <= msg_accept_o && msg_mode_i == `LIU_DM_SMI; // RULE13
      core_init_o    <= init_go;
      core_startup_o <= msg_accept_o && msg_mode_i == `LIU_DM_STARTUP;
      if (nmi_req && !nmi_block_q) begin
        nmi_block_q <= 1'b1; // RULE17
      end else if (core_interrupt_return_instruction_i) begin
        nmi_block_q <= 1'b0; // RULE17
      end
      if (core_ack_i) begin
        core_intr_o <= 1'b0;
        slot_busy_q <= 1'b0;
      end
      if (!slot_busy_q && (fixed_msg || lv_hit) &&
          (fixed_msg ? msg_vector_i : lv_vec) > task_priority_i) begin
        core_intr_o   <= 1'b1;
        core_vector_o <= fixed_msg ? msg_vector_i : lv_vec;
        slot_busy_q   <= 1'b1; // RULE8
      end
    end
  end

  // outgoing command-register messages
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_valid_o         <= 1'b0;
      out_mode_i_unused_o <= `LIU_DM_FIXED;
      out_vector_o        <= 8'h00;
      out_logical_o       <= 1'b0;
      out_dest_o          <= 8'h00;
      out_level_o         <= 1'b0;
      out_assert_o        <= 1'b0;
    end else begin
      out_valid_o <= cmd_wr_i && mode_legal(cmd_mode_i, LATE[0]); // RULE7 RULE13
      if (cmd_wr_i) begin
        out_mode_i_unused_o <= cmd_mode_i;
        out_vector_o        <= cmd_vector_i;
        out_logical_o       <= cmd_logical_i;
        out_dest_o          <= cmd_dest_i;
        out_level_o         <= cmd_level_i && !edge_forced(cmd_mode_i, cmd_level_i, cmd_assert_i); // RULE4
        out_assert_o        <= cmd_assert_i;
      end
    end
  end
endmodule // liu_local_unit

/* File: design/liu_pin_sync.v */
// liu_pin_sync.v: three-flop pin synchroniser with agreement filter
// assumes an asynchronous input and one clock
`include "liu_consts.vh"
module liu_pin_sync (
  input  wire ref_clk_i,
  input  wire rst_i,
  input  wire pin_i,
  output reg  level_o
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_o <= s3_q;
      end
    end
  end
endmodule // liu_pin_sync

/* File: pkg/liu_consts.vh */
// liu_consts.vh: constants shared by the local interrupt unit files
// assumes inclusion by bare name from design files
`ifndef LIU_CONSTS_VH
`define LIU_CONSTS_VH
// delivery modes (3-bit)
`define LIU_DM_FIXED    3'h0
`define LIU_DM_LOWEST   3'h1
`define LIU_DM_SMI      3'h2
`define LIU_DM_REMOTE   3'h3
`define LIU_DM_NMI      3'h4
`define LIU_DM_INIT     3'h5
`define LIU_DM_STARTUP  3'h6
`define LIU_DM_EXTINT   3'h7
// local vector table entries
`define LIU_LVT_N       6
`define LIU_LVT_TIMER   0
`define LIU_LVT_LINT0   1
`define LIU_LVT_LOCAL_INTERRUPT_PIN_ONE   2
`define LIU_LVT_ERROR   3
`define LIU_LVT_PERF    4
`define LIU_LVT_THERM   5
// lvt entry word: [7:0] vector, [10:8] mode, [13] polarity, [15] level, [16] mask
`define LIU_LVT_W       17
`define LIU_LVT_MASK    16
`define LIU_LVT_LEVEL   15
`define LIU_LVT_POL     13
`define LIU_LVT_MODE_HI 10
`define LIU_LVT_MODE_LO 8
`define LIU_LVT_RST     17'h10000
// destination format
`define LIU_DFR_FLAT    4'hf
`define LIU_DFR_CLUSTER 4'h0
`define LIU_DEST_ALL    8'hff
`define LIU_CLUS_ALL    4'hf
// error status bits
`define LIU_ERR_W       8
`define LIU_ERR_SEND    0
`define LIU_ERR_RECV    1
`define LIU_ERR_ILLVEC  6
`define LIU_ERR_ILLMODE 7
`define LIU_ERR_RST     8'h00
`define LIU_VEC_MIN     8'h10
// variants
`define LIU_VAR_EARLY   1'b0
`define LIU_VAR_LATE    1'b1
`define LIU_ID_W_EARLY  4
`endif

/* File: tb/liu_core_model.sv */
// liu_core_model.sv: behavioural core facing the unit's core side
// assumes the unit's clock and reset; acks each interrupt unless stalled
module liu_core_model (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       intr_i,
  input  wire logic [7:0] vec_i,
  input  wire logic       stall_i,
  input  wire logic       interrupt_return_instruction_req_i,
  output logic            ack_o,
  output logic            interrupt_return_instruction_o,
  output logic [7:0]      last_vec_o
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o      <= 1'b0;
      interrupt_return_instruction_o     <= 1'b0;
      last_vec_o <= 8'h00;
    end else begin
      ack_o  <= intr_i & ~stall_i & ~ack_o;
      interrupt_return_instruction_o <= interrupt_return_instruction_req_i & ~interrupt_return_instruction_o;
      if (intr_i & ~stall_i & ~ack_o)
        last_vec_o <= vec_i;
    end
  end
endmodule // liu_core_model

/* File: tb/liu_local_unit_properties.sv */
// liu_local_unit_properties.sv: port checker for the local interrupt unit
// assumes bind onto liu_local_unit, one clock, async reset
module liu_chk #(
  parameter LATE = 1
) (
  input wire        ref_clk_i,
  input wire        rst_i,
  input wire        sw_enable_i,
  input wire [7:0]  unit_id_i,
  input wire [3:0]  dest_format_i,
  input wire [2:0]  lvt_rsel_i,
  input wire [16:0] lvt_rdata_o,
  input wire [7:0]  unit_id_o,
  input wire        msg_valid_i,
  input wire [2:0]  msg_mode_i,
  input wire [7:0]  msg_vector_i,
  input wire        msg_accept_o,
  input wire        arb_join_o,
  input wire        focus_claim_o,
  input wire        cmd_wr_i,
  input wire [2:0]  cmd_mode_i,
  input wire        cmd_level_i,
  input wire        cmd_assert_i,
  input wire        out_valid_o,
  input wire        out_level_o,
  input wire        core_intr_o,
  input wire        core_nmi_o,
  input wire        core_interrupt_return_instruction_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic nmi_blk_q;
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) nmi_blk_q <= 1'b0;
    else if (core_nmi_o) nmi_blk_q <= 1'b1;
    else if (core_interrupt_return_instruction_i) nmi_blk_q <= 1'b0;
  end
  sequence s_nmi_in;
    msg_valid_i && msg_mode_i == 3'h4 && msg_accept_o;
  endsequence
  sequence s_init_deassert;
    cmd_wr_i && cmd_mode_i == 3'h5 && cmd_level_i && !cmd_assert_i;
  endsequence
  sequence s_cmd_plain;
    cmd_wr_i && !(cmd_mode_i == 3'h5 && cmd_level_i && !cmd_assert_i) && !(LATE && cmd_mode_i == 3'h3);
  endsequence
  a_disabled_mask_set: assert property (
    (!sw_enable_i && lvt_rsel_i < 3'h5) [*5] |-> lvt_rdata_o[16]) else $error("mask clear while disabled");
  a_disabled_refuse: assert property (
    !sw_enable_i && !$past(sw_enable_i) && msg_valid_i && !(msg_mode_i inside {3'h2, 3'h4, 3'h5, 3'h6})
    |-> !msg_accept_o) else $error("message taken while disabled");
  a_cmd_edge_out: assert property (
    s_cmd_plain |=> out_valid_o && !out_level_o) else $error("command not sent as edge");
  a_init_deassert_lvl: assert property (
    s_init_deassert |=> out_valid_o && out_level_o) else $error("init deassert not level");
  a_id_width: assert property (
    $stable(unit_id_i) [*2] |=> unit_id_o == ($past(unit_id_i) & (LATE ? 8'hff : 8'h0f)))
    else $error("unit id width wrong");
  a_remote_refused: assert property (
    LATE && msg_valid_i && msg_mode_i == 3'h3 |-> !msg_accept_o) else $error("remote read taken");
  a_lowest_abstain: assert property (
    msg_valid_i && msg_mode_i == 3'h1 && core_intr_o |-> !arb_join_o) else $error("joined with busy slot");
  a_flat_ignored: assert property (
    LATE && dest_format_i == 4'hf && $past(dest_format_i) == 4'hf && msg_valid_i |-> !msg_accept_o)
    else $error("flat model message taken");
  a_no_focus: assert property (
    LATE && msg_valid_i |-> !focus_claim_o) else $error("focus claim in late variant");
  a_bad_vector: assert property (
    msg_valid_i && msg_mode_i == 3'h0 && msg_vector_i < 8'h10 |-> !msg_accept_o) else $error("low vector taken");
  a_nmi_deliver: assert property (
    !nmi_blk_q && !core_nmi_o ##0 s_nmi_in |=> core_nmi_o) else $error("nmi not delivered");
  a_nmi_masked: assert property (
    nmi_blk_q && !core_interrupt_return_instruction_i |=> !core_nmi_o) else $error("nmi while masked");
endmodule // liu_chk

/* File: tb/liu_local_unit_tb_top.sv */
// liu_local_unit_tb_top.sv: self-checking bench for the local interrupt unit
// assumes liu_local_unit, liu_core_model and liu_chk compiled first
module liu_local_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i, rst_i, sw_enable_i, focus_check_en_i, lvt_wr_i, err_clr_i, lint0_pin_i, local_interrupt_pin_one_pin_i;
  logic timer_evt_i, perf_ovf_i, thermal_evt_i, msg_valid_i, msg_logical_i, msg_level_i, msg_assert_i;
  logic msg_focus_i, cmd_wr_i, cmd_logical_i, cmd_level_i, cmd_assert_i, core_ack_i, core_interrupt_return_instruction_i;
  logic [2:0]  lvt_sel_i, lvt_rsel_i, msg_mode_i, cmd_mode_i, out_mode_i_unused_o;
  logic [3:0]  dest_format_i;
  logic [7:0]  unit_id_i, logical_dest_i, task_priority_i, msg_vector_i, msg_dest_i, cmd_vector_i, cmd_dest_i;
  logic [16:0] lvt_wdata_i, lvt_rdata_o;
  logic [7:0]  err_status_o, unit_id_o, logical_dest_o, out_vector_o, out_dest_o, core_vector_o, last_vec;
  logic msg_accept_o, arb_join_o, focus_claim_o, out_valid_o, out_logical_o, out_level_o, out_assert_o;
  logic core_intr_o, core_nmi_o, core_smi_o, core_init_o, core_startup_o, stall, interrupt_return_instruction_req, acc, aj, fc;
  int error_cnt, tests_run;
  logic [7:0]  e_id;
  logic e_fc, efc;
  liu_local_unit #(.LATE(1'b1)) i_liu_local_unit (.*);
  liu_local_unit #(.LATE(1'b0)) i_liu_local_unit_early (.*, .lvt_rdata_o(), .err_status_o(), .unit_id_o(e_id),
    .logical_dest_o(), .msg_accept_o(), .arb_join_o(), .focus_claim_o(e_fc), .out_valid_o(),
    .out_mode_i_unused_o(), .out_vector_o(), .out_logical_o(), .out_dest_o(), .out_level_o(), .out_assert_o(),
    .core_intr_o(), .core_vector_o(), .core_nmi_o(), .core_smi_o(), .core_init_o(), .core_startup_o());
  liu_core_model i_liu_core_model (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .intr_i(core_intr_o),
    .vec_i(core_vector_o), .stall_i(stall), .interrupt_return_instruction_req_i(interrupt_return_instruction_req), .ack_o(core_ack_i),
    .interrupt_return_instruction_o(core_interrupt_return_instruction_i), .last_vec_o(last_vec));
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input logic [16:0] g, input logic [16:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic gap;
    repeat (6) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic pulse(ref logic s);
    @(posedge ref_clk_i) #1 s = 1'b1;
    @(posedge ref_clk_i) #1 s = 1'b0;
  endtask
  task automatic snd(input logic [2:0] m, input logic [7:0] v, input logic [7:0] d, input logic l);
    @(posedge ref_clk_i) #1 msg_valid_i = 1'b1;
    {msg_mode_i, msg_vector_i, msg_dest_i, msg_logical_i} = {m, v, d, l};
    #2 {acc, aj, fc, efc} = {msg_accept_o, arb_join_o, focus_claim_o, e_fc};
    @(posedge ref_clk_i) #1 msg_valid_i = 1'b0;
  endtask
  task automatic cmd(input logic [2:0] m, input logic l, input logic a);
    @(posedge ref_clk_i) #1 cmd_wr_i = 1'b1;
    {cmd_mode_i, cmd_level_i, cmd_assert_i, cmd_vector_i, cmd_dest_i} = {m, l, a, 8'h30, 8'h07};
    @(posedge ref_clk_i) #1 cmd_wr_i = 1'b0;
  endtask
  task automatic wl(input logic [2:0] s, input logic [16:0] d);
    @(posedge ref_clk_i) #1 {lvt_wr_i, lvt_sel_i, lvt_wdata_i} = {1'b1, s, d};
    @(posedge ref_clk_i) #1 lvt_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [2:0] s);
    @(posedge ref_clk_i) #1 lvt_rsel_i = s;
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200us;
    error_cnt++;
    $display("mismatch t=%0t watchdog expired", $time);
    final_report;
  end
  initial begin
    {focus_check_en_i, lvt_wr_i, err_clr_i, local_interrupt_pin_one_pin_i, timer_evt_i, perf_ovf_i, thermal_evt_i, msg_valid_i,
     msg_logical_i, msg_level_i, msg_focus_i, cmd_wr_i, cmd_logical_i, cmd_level_i, cmd_assert_i, lvt_sel_i,
     lvt_rsel_i, msg_mode_i, cmd_mode_i, dest_format_i, logical_dest_i, msg_vector_i, msg_dest_i, cmd_vector_i,
     cmd_dest_i, lvt_wdata_i, stall, interrupt_return_instruction_req} = '0;
    {rst_i, sw_enable_i, lint0_pin_i, msg_assert_i, unit_id_i, task_priority_i} = {4'hf, 8'h05, 8'h20};
    repeat (2) @(posedge ref_clk_i);
    #1 rst_i = 1'b0;
    rd(3'd4);
    chk(lvt_rdata_o, 17'h10000);
    rd(3'd5);
    chk(lvt_rdata_o, 17'h10000);
    chk(err_status_o, 8'h00);
    chk(unit_id_o, 8'h05);
    $display("test reset done");
    wl(3'd4, 17'h00060);
    sw_enable_i = 1'b0;
    rd(3'd4);
    chk(lvt_rdata_o, 17'h10060);
    for (int m = 0; m < 8; m++) begin
      snd(m[2:0], 8'h40, 8'h05, 1'b0);
      chk(acc, m == 2 || (m > 3 && m < 7));
      gap;
    end
    sw_enable_i = 1'b1;
    pulse(interrupt_return_instruction_req);
    gap;
    for (int m = 0; m < 8; m++) begin
      snd(m[2:0], 8'h41, 8'h05, 1'b0);
      chk(acc, m != 3);
      if (m == 2) chk(core_smi_o, 1'b1);
      if (m == 5) chk(core_init_o, 1'b1);
      if (m == 6) chk(core_startup_o, 1'b1);
      gap;
    end
    {msg_level_i, msg_assert_i} = 2'b10;
    snd(3'h5, 8'h00, 8'h05, 1'b0);
    chk(core_init_o, 1'b0);
    {msg_level_i, msg_assert_i} = 2'b01;
    gap;
    $display("test enable done");
    pulse(interrupt_return_instruction_req);
    gap;
    snd(3'h4, 8'h00, 8'h05, 1'b0);
    chk(core_nmi_o, 1'b1);
    gap;
    snd(3'h4, 8'h00, 8'h05, 1'b0);
    chk(core_nmi_o, 1'b0);
    pulse(interrupt_return_instruction_req);
    gap;
    msg_level_i = 1'b1;
    snd(3'h4, 8'h00, 8'h05, 1'b0);
    chk(core_nmi_o, 1'b1);
    msg_level_i = 1'b0;
    $display("test nmi done");
    stall = 1'b1;
    snd(3'h0, 8'h42, 8'h05, 1'b0);
    gap;
    snd(3'h1, 8'h43, 8'h05, 1'b0);
    chk(aj, 1'b0);
    stall = 1'b0;
    gap;
    {focus_check_en_i, msg_focus_i} = 2'b11;
    snd(3'h1, 8'h44, 8'h05, 1'b0);
    chk(aj, 1'b1);
    chk(fc, 1'b0);
    chk(efc, 1'b1);
    {focus_check_en_i, msg_focus_i} = 2'b01;
    gap;
    snd(3'h1, 8'h45, 8'h05, 1'b0);
    chk(efc, 1'b0);
    {focus_check_en_i, msg_focus_i} = 2'b00;
    logical_dest_i = 8'h21;
    gap;
    chk(logical_dest_o, 8'h21);
    snd(3'h0, 8'h46, 8'h23, 1'b1);
    chk(acc, 1'b1);
    gap;
    snd(3'h0, 8'h47, 8'h34, 1'b1);
    chk(acc, 1'b0);
    dest_format_i = 4'hf;
    gap;
    snd(3'h0, 8'h48, 8'h05, 1'b0);
    chk(acc, 1'b0);
    dest_format_i = 4'h0;
    $display("test delivery done");
    cmd(3'h0, 1'b1, 1'b1);
    chk({out_valid_o, out_level_o}, 2'b10);
    cmd(3'h5, 1'b1, 1'b0);
    chk({out_valid_o, out_level_o}, 2'b11);
    cmd(3'h4, 1'b1, 1'b1);
    chk({out_valid_o, out_level_o}, 2'b10);
    cmd(3'h2, 1'b0, 1'b1);
    chk(out_mode_i_unused_o, 3'h2);
    chk({out_assert_o, out_vector_o, out_dest_o}, 17'h13007);
    chk(out_logical_o, 1'b0);
    cmd(3'h3, 1'b0, 1'b1);
    chk(out_valid_o, 1'b0);
    gap;
    chk(err_status_o, 8'h83);
    pulse(err_clr_i);
    gap;
    chk(err_status_o, 8'h00);
    wl(3'd3, 17'h00058);
    snd(3'h0, 8'h05, 8'h05, 1'b0);
    chk(acc, 1'b0);
    gap;
    chk(err_status_o[6], 1'b1);
    chk(last_vec, 8'h58);
    $display("test command done");
    wl(3'd4, 17'h00060);
    pulse(perf_ovf_i);
    gap;
    chk(last_vec, 8'h60);
    wl(3'd5, 17'h00070);
    pulse(thermal_evt_i);
    gap;
    chk(last_vec, 8'h70);
    wl(3'd1, 17'h02050);
    lint0_pin_i = 1'b0;
    gap;
    gap;
    chk(last_vec, 8'h50);
    unit_id_i = 8'h35;
    gap;
    chk(unit_id_o, 8'h35);
    chk(e_id, 8'h05);
    $display("test local sources done");
    final_report;
  end
endmodule // liu_local_unit_tb_top
bind liu_local_unit liu_chk #(.LATE(LATE)) i_liu_chk (.*);
